// file: shared/ast_pkg.sv
package ast_pkg;
  // byte addresses of the register words
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PRE = 8'h08;
  localparam logic [7:0] OFF_ACQ = 8'h0c;
  localparam logic [7:0] OFF_GRD = 8'h10;
  localparam logic [7:0] OFF_CAP = 8'h14;
  localparam logic [7:0] OFF_RES0H = 8'h18;
  localparam logic [7:0] OFF_RES0L = 8'h1c;
  localparam logic [7:0] OFF_RES1H = 8'h20;
  localparam logic [7:0] OFF_RES1L = 8'h24;
  // control word bit positions
  localparam int CTRL_ON = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_DS = 2;
  localparam int CTRL_INV = 3;
  localparam int CTRL_FM = 4;
  localparam int CTRL_RC = 5;
  // guard register bit positions
  localparam int GRD_B_OE = 7;
  localparam int GRD_A_OE = 6;
  localparam int GRD_POL = 5;
  // status field positions
  localparam int STAT_PAIR = 2;
  localparam logic [1:0] STG_IDLE = 2'b00;
  localparam logic [1:0] STG_PRE = 2'b01;
  localparam logic [1:0] STG_ACQ = 2'b10;
  localparam logic [1:0] STG_CONV = 2'b11;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] TICK_DIV = 2'd3;
  localparam logic [3:0] CONV_CYCLES = 4'd10;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE = 4'b0010,
    ST_ACQ = 4'b0100,
    ST_CONV = 4'b1000
  } ast_state_t;
endpackage : ast_pkg

// file: rtl/ast_adc_ctrl.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ast_adc_ctrl
  import ast_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_clk_i,
  input wire logic [9:0] conv_data_i,
  output logic guard_pin_a_o,
  output logic guard_pin_a_oe_n_o,
  output logic guard_pin_b_o,
  output logic guard_pin_b_oe_n_o,
  output logic [7:0] cap_enable_o,
  output logic [1:0] stage_o
);
  logic converter_enable_q;
  logic go_q;
  logic double_sample_enable_q;
  logic polarity_invert_enable_q;
  logic result_format_select_q;
  logic rc_sel_q;
  logic [6:0] precharge_count_q;
  logic [6:0] acquisition_count_q;
  logic guard_b_output_enable_q;
  logic guard_a_output_enable_q;
  logic guard_polarity_q;
  logic [2:0] extra_cap_select_q;
  logic [7:0] res_h_q [2];
  logic [7:0] res_l_q [2];
  ast_state_t state_q;
  logic pair_q;
  logic [6:0] cnt_q;
  logic [3:0] conv_cnt_q;
  logic guard_q;
  logic [1:0] div_q;
  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic tick;
  logic wr;
  logic rd;
  logic mapped;
  logic go_set;
  logic done;
  logic pol_eff;
  logic [7:0] stat_byte;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign go_set = wr && paddr == OFF_CTRL && pwdata[CTRL_GO] && converter_enable_q;
  assign done = state_q == ST_CONV && conv_cnt_q == CONV_CYCLES;
  assign stat_byte = {5'd0, pair_q && go_q, stage_o};
  assign pol_eff = guard_polarity_q ^ (double_sample_enable_q && polarity_invert_enable_q
                                       && pair_q);

  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      OFF_CTRL, OFF_STAT, OFF_PRE, OFF_ACQ, OFF_GRD, OFF_CAP,
      OFF_RES0H, OFF_RES0L, OFF_RES1H, OFF_RES1L: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // rc clock is asynchronous: two stages before any logic, third for the edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end
    else
    begin
      rc_s1_q <= rc_clk_i;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 2'd0;
    else if (div_q == TICK_DIV)
      div_q <= 2'd0;
    else
      div_q <= div_q + 2'd1;
  end

  assign tick = rc_sel_q ? (rc_s2_q && !rc_s3_q) : (div_q == TICK_DIV);

  // apb slave: zero wait states, unmapped reads zero with error
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd)
      begin
        case (paddr)
          OFF_CTRL: prdata <= {26'd0, rc_sel_q, result_format_select_q,
                               polarity_invert_enable_q, double_sample_enable_q,
                               go_q, converter_enable_q};
          OFF_STAT: prdata <= {24'd0, stat_byte};
          OFF_PRE: prdata <= {25'd0, precharge_count_q};
          OFF_ACQ: prdata <= {25'd0, acquisition_count_q};
          OFF_GRD: prdata <= {24'd0, guard_b_output_enable_q, guard_a_output_enable_q,
                              guard_polarity_q, 5'd0};
          OFF_CAP: prdata <= {29'd0, extra_cap_select_q};
          OFF_RES0H: prdata <= {24'd0, res_h_q[0]};
          OFF_RES0L: prdata <= {24'd0, res_l_q[0]};
          OFF_RES1H: prdata <= {24'd0, res_h_q[1]};
          OFF_RES1L: prdata <= {24'd0, res_l_q[1]};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      converter_enable_q <= 1'b0;
      double_sample_enable_q <= 1'b0;
      polarity_invert_enable_q <= 1'b0;
      result_format_select_q <= 1'b0;
      rc_sel_q <= 1'b0;
      precharge_count_q <= 7'd0;
      acquisition_count_q <= 7'd0;
      guard_b_output_enable_q <= 1'b0;
      guard_a_output_enable_q <= 1'b0;
      guard_polarity_q <= 1'b0;
      extra_cap_select_q <= 3'd0;
    end
    else if (wr)
    begin
      case (paddr)
        OFF_CTRL:
        begin
          converter_enable_q <= pwdata[CTRL_ON];
          double_sample_enable_q <= pwdata[CTRL_DS];
          polarity_invert_enable_q <= pwdata[CTRL_INV];
          result_format_select_q <= pwdata[CTRL_FM];
          rc_sel_q <= pwdata[CTRL_RC];
        end
        OFF_PRE: precharge_count_q <= pwdata[6:0];
        OFF_ACQ: acquisition_count_q <= pwdata[6:0];
        OFF_GRD:
        begin
          guard_b_output_enable_q <= pwdata[GRD_B_OE];
          guard_a_output_enable_q <= pwdata[GRD_A_OE];
          guard_polarity_q <= pwdata[GRD_POL];
        end
        OFF_CAP: extra_cap_select_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // go set by software, cleared by hardware
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      go_q <= 1'b0;
    else if (go_set)
      go_q <= 1'b1;
    else if (!converter_enable_q || (done && (pair_q || !double_sample_enable_q)))
      go_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !converter_enable_q)
    begin
      state_q <= ST_IDLE;
      pair_q <= 1'b0;
      cnt_q <= 7'd0;
      conv_cnt_q <= 4'd0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (go_set)
          begin
            pair_q <= 1'b0;
            cnt_q <= 7'd0;
            if (precharge_count_q != 7'd0)
              state_q <= ST_PRE;
            else if (acquisition_count_q != 7'd0)
              state_q <= ST_ACQ;
            else
              state_q <= ST_CONV;
          end
        ST_PRE:
          if (tick && cnt_q == precharge_count_q - 7'd1)
          begin
            cnt_q <= 7'd0;
            state_q <= acquisition_count_q != 7'd0 ? ST_ACQ : ST_CONV;
          end
          else if (tick)
            cnt_q <= cnt_q + 7'd1;
        ST_ACQ:
          if (tick && cnt_q == acquisition_count_q - 7'd1)
          begin
            cnt_q <= 7'd0;
            state_q <= ST_CONV;
          end
          else if (tick)
            cnt_q <= cnt_q + 7'd1;
        ST_CONV:
          if (done)
          begin
            conv_cnt_q <= 4'd0;
            if (double_sample_enable_q && !pair_q)
            begin
              pair_q <= 1'b1;
              if (precharge_count_q != 7'd0)
                state_q <= ST_PRE;
              else if (acquisition_count_q != 7'd0)
                state_q <= ST_ACQ;
              else
                state_q <= ST_CONV;
            end
            else
            begin
              pair_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          else
            conv_cnt_q <= conv_cnt_q + 4'd1;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_h_q[0] <= RST_BYTE;
      res_l_q[0] <= RST_BYTE;
      res_h_q[1] <= RST_BYTE;
      res_l_q[1] <= RST_BYTE;
    end
    else if (done)
    begin
      if (result_format_select_q)
      begin
        res_h_q[pair_q] <= {6'd0, conv_data_i[9:8]};
        res_l_q[pair_q] <= conv_data_i[7:0];
      end
      else
      begin
        res_h_q[pair_q] <= conv_data_i[9:2];
        res_l_q[pair_q] <= {conv_data_i[1:0], 6'd0};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stage_o <= STG_IDLE;
    else
      case (state_q)
        ST_PRE: stage_o <= STG_PRE;
        ST_ACQ: stage_o <= STG_ACQ;
        ST_CONV: stage_o <= STG_CONV;
        default: stage_o <= STG_IDLE;
      endcase
  end

  // guard level: starts at polarity, a flips at acquisition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      guard_q <= 1'b0;
    else if (state_q == ST_PRE || state_q == ST_IDLE)
      guard_q <= pol_eff;
    else if (state_q == ST_ACQ)
      guard_q <= !pol_eff;
  end

  // guard pins driven while enabled and converter on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      guard_pin_a_o <= 1'b0;
      guard_pin_b_o <= 1'b0;
      guard_pin_a_oe_n_o <= 1'b1;
      guard_pin_b_oe_n_o <= 1'b1;
    end
    else
    begin
      guard_pin_a_o <= guard_q;
      guard_pin_b_o <= pol_eff;
      guard_pin_a_oe_n_o <= !(guard_a_output_enable_q && converter_enable_q);
      guard_pin_b_oe_n_o <= !(guard_b_output_enable_q && converter_enable_q);
    end
  end

  // capacitor thermometer decode, 4 pF per step
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_cap
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          cap_enable_o[gi] <= 1'b0;
        else
          cap_enable_o[gi] <= gi != 0 && gi <= int'(extra_cap_select_q);
      end
    end
  endgenerate

  property p_stat_idle;
    @(posedge clk_i) disable iff (rst_i) state_q == ST_IDLE |=> stage_o == STG_IDLE;
  endproperty
  a_stat_idle: assert property (p_stat_idle) else $error("stage not idle");
  property p_pre_skip;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && go_set && precharge_count_q == 7'd0 |=> state_q != ST_PRE;
  endproperty
  a_pre_skip: assert property (p_pre_skip) else $error("pre-charge not skipped");
  property p_acq_skip;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_PRE && tick && cnt_q == precharge_count_q - 7'd1 && converter_enable_q
      && acquisition_count_q == 7'd0 |=> state_q == ST_CONV;
  endproperty
  a_acq_skip: assert property (p_acq_skip) else $error("acquisition not skipped");
  property p_acq_order;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_ACQ |=> state_q inside {ST_ACQ, ST_CONV, ST_IDLE};
  endproperty
  a_acq_order: assert property (p_acq_order) else $error("bad stage order");
  property p_pair;
    @(posedge clk_i) disable iff (rst_i) !go_q |-> !pair_q;
  endproperty
  a_pair: assert property (p_pair) else $error("pair set while idle");
  property p_go_clear;
    @(posedge clk_i) disable iff (rst_i)
      done && !double_sample_enable_q && !go_set |=> !go_q;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go not cleared");
  property p_second;
    @(posedge clk_i) disable iff (rst_i)
      done && double_sample_enable_q && !pair_q && converter_enable_q |=> pair_q;
  endproperty
  a_second: assert property (p_second) else $error("no second conversion");
  property p_guard_off;
    @(posedge clk_i) disable iff (rst_i) !converter_enable_q |=> guard_pin_a_oe_n_o;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("guard a driven while off");
  property p_acq_toggle;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_ACQ && $past(state_q) == ST_PRE |=> guard_q == !pol_eff;
  endproperty
  a_acq_toggle: assert property (p_acq_toggle) else $error("guard a not toggled");
  property p_left;
    @(posedge clk_i) disable iff (rst_i)
      done && !result_format_select_q && !pair_q |=> res_l_q[0][5:0] == 6'd0;
  endproperty
  a_left: assert property (p_left) else $error("left low bits not zero");
endmodule // ast_adc_ctrl
`default_nettype wire

// file: verif/ast_adc_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module ast_adc_ctrl_bench;
  import ast_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rc_clk_i = 1'b0;
  logic [9:0] conv_data_i = 10'h000;
  logic [31:0] prdata;
  logic pready, pslverr, guard_pin_a_o, guard_pin_a_oe_n_o, guard_pin_b_o, guard_pin_b_oe_n_o;
  logic [7:0] cap_enable_o;
  logic [1:0] stage_o;
  int fail_count = 0;
  int checked = 0;
  logic [1:0] prev_stg = 2'b00;
  logic [1:0] seg_stg[$];
  int seg_len[$];
  logic seg_ga[$];
  logic [9:0] next_data;
  ast_adc_ctrl ast_adc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_clk_i(rc_clk_i), .conv_data_i(conv_data_i),
    .guard_pin_a_o(guard_pin_a_o), .guard_pin_a_oe_n_o(guard_pin_a_oe_n_o),
    .guard_pin_b_o(guard_pin_b_o), .guard_pin_b_oe_n_o(guard_pin_b_oe_n_o),
    .cap_enable_o(cap_enable_o), .stage_o(stage_o));
  always #10 clk_i = ~clk_i;
  // rc clock offset so its edges never line up with clk_i
  initial
  begin
    #3;
    forever #100 rc_clk_i = ~rc_clk_i;
  end
  // run lengths of the stage field; guard sampled on each stage's second cycle to dodge lag
  always @(posedge clk_i)
  begin
    if (stage_o !== prev_stg)
    begin
      if (prev_stg === STG_CONV)
        conv_data_i <= next_data;
      seg_stg.push_back(stage_o);
      seg_len.push_back(1);
      seg_ga.push_back(guard_pin_a_o);
    end
    else if (seg_len.size() > 0)
    begin
      seg_len[$] = seg_len[$] + 1;
      if (seg_len[$] == 2)
        seg_ga[$] = guard_pin_a_o;
    end
    prev_stg <= stage_o;
  end
  function automatic void chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endfunction
  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1)
    begin
      chk("pready", 32'h1, 32'h0);
      print_verdict();
    end
    else
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    `CHK(nm, x, r);
  endtask
  task automatic seg(input int i, input logic [1:0] s, input int n, input int per, input logic g);
    `CHK("stage order", s, seg_stg[i]);
    if (s === STG_CONV)
      `CHK("conv length", int'(CONV_CYCLES) + 1, seg_len[i]);
    else
    begin
      `CHK("stage length", 1, seg_len[i] > per * (n - 1) && seg_len[i] <= per * n + 2);
      `CHK("guard a level", g, seg_ga[i]);
    end
  endtask
  task automatic run(input logic [7:0] c, input int np, input int na, input int per,
                     input logic pol, input logic [9:0] d0, input logic [9:0] d1);
    logic [31:0] r;
    logic e;
    logic seen1;
    logic [3:0] mask;
    logic [9:0] dd;
    logic g;
    int n;
    int k;
    int i;
    int ns;
    seen1 = 1'b0;
    mask = 4'h0;
    n = 0;
    ns = ((np > 0) + (na > 0) + 1) * (c[CTRL_DS] + 1) + 1;
    seg_stg.delete();
    seg_len.delete();
    seg_ga.delete();
    conv_data_i <= d0;
    next_data = d1;
    // go is refused until the converter is already on
    wr(OFF_CTRL, {24'h0, c & 8'hfd});
    wr(OFF_CTRL, {24'h0, c});
    do
    begin
      apb(OFF_STAT, 1'b0, 32'h0, r, e);
      seen1 = seen1 | r[STAT_PAIR];
      mask[r[1:0]] = 1'b1;
      n++;
    end
    while (!(seg_stg.size() > 0 && seg_stg[$] === STG_IDLE) && n < 600);
    `CHK("run finished", 1, n < 600);
    `CHK("pair seen", c[CTRL_DS], seen1);
    `CHK("stages seen", {1'b1, na > 0, np > 0}, mask[3:1]);
    `CHK("segments", ns, seg_stg.size());
    if (seg_stg.size() == ns)
    begin
      i = 0;
      for (k = 0; k <= int'(c[CTRL_DS]); k++)
      begin
        g = pol ^ (k == 1 && c[CTRL_INV]);
        if (np > 0)
          seg(i++, STG_PRE, np, per, g);
        if (na > 0)
          seg(i++, STG_ACQ, na, per, !g);
        seg(i++, STG_CONV, 0, per, g);
      end
    end
    for (k = 0; k <= int'(c[CTRL_DS]); k++)
    begin
      dd = (k == 1) ? d1 : d0;
      if (c[CTRL_FM])
      begin
        rdc(k ? OFF_RES1H : OFF_RES0H, {22'h0, dd[9:8]}, "right high");
        rdc(k ? OFF_RES1L : OFF_RES0L, {24'h0, dd[7:0]}, "right low");
      end
      else
      begin
        rdc(k ? OFF_RES1H : OFF_RES0H, {24'h0, dd[9:2]}, "left high");
        rdc(k ? OFF_RES1L : OFF_RES0L, {24'h0, dd[1:0], 6'h0}, "left low");
      end
    end
    rdc(OFF_CTRL, {24'h0, c & 8'hfd}, "go cleared");
    rdc(OFF_STAT, 32'h0, "status idle");
  endtask
  initial
  begin
    logic [31:0] r;
    logic e;
    int k;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k <= OFF_CAP; k += 4)
      rdc(8'(k), 32'h0, "reset value");
    apb(8'h28, 1'b0, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e);
    `CHK("unmapped data", 32'h0, r);
    wr(OFF_PRE, 32'hff);
    rdc(OFF_PRE, 32'h7f, "pre mask");
    wr(OFF_ACQ, 32'hff);
    rdc(OFF_ACQ, 32'h7f, "acq mask");
    wr(OFF_GRD, 32'hff);
    rdc(OFF_GRD, 32'he0, "grd mask");
    wr(OFF_CAP, 32'hff);
    rdc(OFF_CAP, 32'h07, "cap mask");
    wr(OFF_CTRL, 32'h02);
    repeat (3) @(posedge clk_i);
    `CHK("go while off", STG_IDLE, stage_o);
    rdc(OFF_CTRL, 32'h0, "go refused");
    for (k = 0; k < 8; k++)
    begin
      wr(OFF_CAP, 32'(k));
      @(posedge clk_i);
      `CHK("cap decode", 8'((16'h1 << (k + 1)) - 16'h2), cap_enable_o);
    end
    wr(OFF_PRE, 32'h3);
    wr(OFF_ACQ, 32'h2);
    wr(OFF_GRD, 32'he0);
    run(8'h03, 3, 2, int'(TICK_DIV) + 1, 1'b1, 10'h2b5, 10'h000);
    `CHK("oe a", 1'b0, guard_pin_a_oe_n_o);
    `CHK("oe b", 1'b0, guard_pin_b_oe_n_o);
    `CHK("guard b", 1'b1, guard_pin_b_o);
    wr(OFF_PRE, 32'h0);
    wr(OFF_GRD, 32'hc0);
    run(8'h13, 0, 2, int'(TICK_DIV) + 1, 1'b0, 10'h3ca, 10'h000);
    wr(OFF_PRE, 32'h2);
    wr(OFF_GRD, 32'he0);
    run(8'h0f, 2, 2, int'(TICK_DIV) + 1, 1'b1, 10'h155, 10'h0aa);
    rdc(OFF_GRD, 32'he0, "stored polarity");
    wr(OFF_ACQ, 32'h3);
    run(8'h23, 2, 3, 10, 1'b1, 10'h201, 10'h000);
    wr(OFF_PRE, 32'h7f);
    wr(OFF_ACQ, 32'h0);
    run(8'h17, 127, 0, int'(TICK_DIV) + 1, 1'b1, 10'h3ff, 10'h001);
    wr(OFF_GRD, 32'h40);
    repeat (2) @(posedge clk_i);
    `CHK("oe b off", 1'b1, guard_pin_b_oe_n_o);
    `CHK("oe a on", 1'b0, guard_pin_a_oe_n_o);
    wr(OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("oe a released", 1'b1, guard_pin_a_oe_n_o);
    print_verdict();
  end
endmodule // ast_adc_ctrl_bench
`default_nettype wire
